/* File: verilog/port_pins_defs.svh */
`ifndef PORT_PINS_DEFS_SVH
`define PORT_PINS_DEFS_SVH

// printed offsets are not all multiples of four: each is an index, byte address = index * 4
`define IDX_INPUT_LEVELS 8'hce
`define IDX_NARROW_DATA 8'hcf
`define IDX_PORT_A_DATA 8'hd3
`define IDX_PORT_B_DATA 8'hd6
`define IDX_PORT_A_DIR 8'hd0
`define IDX_PORT_B_DIR 8'hd4
`define IDX_QUAD_DIR 8'hc8
`define IDX_QUAD_PULLUP 8'hd8
`define IDX_SECOND_DIR 8'hc1
`define IDX_SECOND_PULLUP 8'hd9
`define IDX_QUAD_DATA 8'hca
`define IDX_SECOND_DATA 8'hc3
`define BYTE_ADDR_W 10
`define RST_BYTE 8'h00
`define RST_NIBBLE 4'h0
`define RST_NARROW 5'h00
`define NARROW_RD_FILL 3'h7
`define QUAD_RD_FILL 4'hf

`endif

/* File: verilog/port_pins_pkg.sv */
package port_pins_pkg;

   typedef struct packed {
      logic [7:0] port_a_out;
      logic [7:0] port_a_dir;
      logic [7:0] port_b_out;
      logic [7:0] port_b_dir;
      logic [7:0] second_out;
      logic [7:0] second_dir;
      logic [7:0] second_pu;
      logic [3:0] quad_out;
      logic [3:0] quad_dir;
      logic [3:0] quad_pu;
      logic [4:0] narrow_out;
   } port_regs_type;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pu;
   } pin_drive_type;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_resp_type;

endpackage

/* File: verilog/pin_sync.sv */
`timescale 1ns/10ps
// two-stage synchroniser for pin levels
module pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_state_type;

   sync_state_type s_q;
   sync_state_type s_d;

   always_comb
   begin
      s_d.first = async_in;
      s_d.second = s_q.first;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign sync_out = s_q.second;

endmodule

/* File: verilog/pin_drive.sv */
`timescale 1ns/10ps
`include "port_pins_defs.svh"
// registered pin drive for one 8-bit port
module pin_drive (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] data,
   input wire logic [7:0] dir,
   input wire logic [7:0] pu_en,
   output port_pins_pkg::pin_drive_type drv
);

   port_pins_pkg::pin_drive_type drv_q;
   port_pins_pkg::pin_drive_type drv_d;

   always_comb
   begin
      drv_d.out = data & dir;
      drv_d.oe = dir;
      drv_d.pu = pu_en & ~dir;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         drv_q <= '0;
      end
      else
      begin
         drv_q <= drv_d;
      end
   end

   assign drv = drv_q;

   AST_PU_ONLY_INPUT: assert property (@(posedge pclk) disable iff (!presetn)
      (drv_q.pu & drv_q.oe) == 8'h00) else $error("pull-up on while driving");
   AST_OUT_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 drv_q.out == ($past(data) & $past(dir))) else $error("pin out wrong");

endmodule

/* File: verilog/port_pins.sv */
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "port_pins_defs.svh"

module port_pins (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   input wire logic [7:0] input_port_pins,
   input wire logic [7:0] port_a_in,
   input wire logic [7:0] port_b_in,
   input wire logic [7:0] second_in,
   input wire logic [3:0] quad_in,
   input wire logic [4:0] narrow_in,
   output logic [7:0] port_a_out,
   output logic [7:0] port_a_oe,
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_oe,
   output logic [7:0] second_out,
   output logic [7:0] second_oe,
   output logic [7:0] second_pullup,
   output logic [3:0] quad_out,
   output logic [3:0] quad_oe,
   output logic [3:0] quad_pullup,
   output logic [4:0] narrow_out
);

   port_pins_pkg::port_regs_type r_q;
   port_pins_pkg::port_regs_type r_d;
   port_pins_pkg::apb_resp_type resp_q;
   port_pins_pkg::apb_resp_type resp_d;
   port_pins_pkg::pin_drive_type drv_a;
   port_pins_pkg::pin_drive_type drv_b;
   port_pins_pkg::pin_drive_type drv_s;
   port_pins_pkg::pin_drive_type drv_qd;
   logic [7:0] input_sync;
   logic [7:0] a_sync;
   logic [7:0] b_sync;
   logic [7:0] s_sync;
   logic [7:0] qd_sync;
   logic [7:0] n_sync;
   logic [7:0] idx;
   logic access;
   logic aligned;
   logic [7:0] quad_view;

   function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
                                             input logic lane);
      merge_byte = lane ? wd[7:0] : old;
   endfunction

   // pin read-back: output pins read latch, inputs read pins
   function automatic logic [7:0] pin_view(input logic [7:0] dat, input logic [7:0] dir,
                                           input logic [7:0] pins);
      pin_view = (dat & dir) | (pins & ~dir);
   endfunction

   pin_sync #(.WIDTH(8)) u_sync_in (.pclk(pclk), .presetn(presetn),
      .async_in(input_port_pins), .sync_out(input_sync));
   pin_sync #(.WIDTH(8)) u_sync_a (.pclk(pclk), .presetn(presetn),
      .async_in(port_a_in), .sync_out(a_sync));
   pin_sync #(.WIDTH(8)) u_sync_b (.pclk(pclk), .presetn(presetn),
      .async_in(port_b_in), .sync_out(b_sync));
   pin_sync #(.WIDTH(8)) u_sync_s (.pclk(pclk), .presetn(presetn),
      .async_in(second_in), .sync_out(s_sync));
   pin_sync #(.WIDTH(8)) u_sync_q (.pclk(pclk), .presetn(presetn),
      .async_in({4'h0, quad_in}), .sync_out(qd_sync));
   pin_sync #(.WIDTH(8)) u_sync_n (.pclk(pclk), .presetn(presetn),
      .async_in({3'h0, narrow_in}), .sync_out(n_sync));

   pin_drive u_drv_a (.pclk(pclk), .presetn(presetn), .data(r_q.port_a_out),
      .dir(r_q.port_a_dir), .pu_en(`RST_BYTE), .drv(drv_a));
   pin_drive u_drv_b (.pclk(pclk), .presetn(presetn), .data(r_q.port_b_out),
      .dir(r_q.port_b_dir), .pu_en(`RST_BYTE), .drv(drv_b));
   pin_drive u_drv_s (.pclk(pclk), .presetn(presetn), .data(r_q.second_out),
      .dir(r_q.second_dir), .pu_en(r_q.second_pu), .drv(drv_s));
   pin_drive u_drv_q (.pclk(pclk), .presetn(presetn), .data({4'h0, r_q.quad_out}),
      .dir({4'h0, r_q.quad_dir}), .pu_en({4'h0, r_q.quad_pu}), .drv(drv_qd));

   assign idx = paddr[9:2];
   assign aligned = (paddr[1:0] == 2'b00) && (paddr[31:`BYTE_ADDR_W] == '0);
   assign access = psel && penable && !resp_q.pready;
   // quad read-back, only the low nibble is used
   assign quad_view = pin_view({4'h0, r_q.quad_out}, {4'h0, r_q.quad_dir}, qd_sync);

   always_comb
   begin
      r_d = r_q;
      resp_d.pready = access;
      resp_d.pslverr = 1'b0;
      resp_d.prdata = '0;
      if (access)
      begin
         if (!aligned)
         begin
            resp_d.pslverr = 1'b1;
         end
         else if (pwrite)
         begin
            case (idx)
               `IDX_PORT_A_DATA: r_d.port_a_out = merge_byte(r_q.port_a_out, pwdata, pstrb[0]);
               `IDX_PORT_A_DIR: r_d.port_a_dir = merge_byte(r_q.port_a_dir, pwdata, pstrb[0]);
               `IDX_PORT_B_DATA: r_d.port_b_out = merge_byte(r_q.port_b_out, pwdata, pstrb[0]);
               `IDX_PORT_B_DIR: r_d.port_b_dir = merge_byte(r_q.port_b_dir, pwdata, pstrb[0]);
               `IDX_SECOND_DATA: r_d.second_out = merge_byte(r_q.second_out, pwdata, pstrb[0]);
               `IDX_SECOND_DIR: r_d.second_dir = merge_byte(r_q.second_dir, pwdata, pstrb[0]);
               `IDX_SECOND_PULLUP: r_d.second_pu = merge_byte(r_q.second_pu, pwdata, pstrb[0]);
               `IDX_QUAD_DATA: r_d.quad_out = pstrb[0] ? pwdata[3:0] : r_q.quad_out;
               `IDX_QUAD_DIR: r_d.quad_dir = pstrb[0] ? pwdata[3:0] : r_q.quad_dir;
               `IDX_QUAD_PULLUP: r_d.quad_pu = pstrb[0] ? pwdata[3:0] : r_q.quad_pu;
               `IDX_NARROW_DATA: r_d.narrow_out = pstrb[0] ? pwdata[4:0] : r_q.narrow_out;
               `IDX_INPUT_LEVELS: r_d = r_q;
               default: resp_d.pslverr = 1'b1;
            endcase
         end
         else
         begin
            case (idx)
               `IDX_INPUT_LEVELS: resp_d.prdata[7:0] = input_sync;
               `IDX_PORT_A_DATA:
                  resp_d.prdata[7:0] = pin_view(r_q.port_a_out, r_q.port_a_dir, a_sync);
               `IDX_PORT_B_DATA: resp_d.prdata[7:0] = r_q.port_b_out;
               `IDX_SECOND_DATA:
                  resp_d.prdata[7:0] = pin_view(r_q.second_out, r_q.second_dir, s_sync);
               `IDX_SECOND_PULLUP: resp_d.prdata[7:0] = r_q.second_pu;
               `IDX_QUAD_DATA: resp_d.prdata[7:0] = {`QUAD_RD_FILL, quad_view[3:0]};
               `IDX_QUAD_PULLUP: resp_d.prdata[7:0] = {`QUAD_RD_FILL, r_q.quad_pu};
               `IDX_NARROW_DATA: resp_d.prdata[7:0] = {`NARROW_RD_FILL, n_sync[4:0]};
               // direction registers read as zero (write-only)
               `IDX_PORT_A_DIR, `IDX_PORT_B_DIR, `IDX_SECOND_DIR, `IDX_QUAD_DIR:
                  resp_d.prdata = '0;
               default: resp_d.pslverr = 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r_q.port_a_out <= `RST_BYTE;
         r_q.port_a_dir <= `RST_BYTE;
         r_q.port_b_out <= `RST_BYTE;
         r_q.port_b_dir <= `RST_BYTE;
         r_q.second_out <= `RST_BYTE;
         r_q.second_dir <= `RST_BYTE;
         r_q.second_pu <= `RST_BYTE;
         r_q.quad_out <= `RST_NIBBLE;
         r_q.quad_dir <= `RST_NIBBLE;
         r_q.quad_pu <= `RST_NIBBLE;
         r_q.narrow_out <= `RST_NARROW;
         resp_q <= '0;
      end
      else
      begin
         r_q <= r_d;
         resp_q <= resp_d;
      end
   end

   // narrow port has no direction register: always driven
   logic [4:0] narrow_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         narrow_q <= `RST_NARROW;
      end
      else
      begin
         narrow_q <= r_q.narrow_out;
      end
   end

   assign pready = resp_q.pready;
   assign pslverr = resp_q.pslverr;
   assign prdata = resp_q.prdata;
   assign port_a_out = drv_a.out;
   assign port_a_oe = drv_a.oe;
   assign port_b_out = drv_b.out;
   assign port_b_oe = drv_b.oe;
   assign second_out = drv_s.out;
   assign second_oe = drv_s.oe;
   assign second_pullup = drv_s.pu;
   assign quad_out = drv_qd.out[3:0];
   assign quad_oe = drv_qd.oe[3:0];
   assign quad_pullup = drv_qd.pu[3:0];
   assign narrow_out = narrow_q;

   AST_IN_READ: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pwrite && aligned && idx == `IDX_INPUT_LEVELS
      |=> prdata[7:0] == $past(input_sync) && pready) else $error("input read wrong");
   AST_DIR_OE: assert property (@(posedge pclk) disable iff (!presetn)
      access && pwrite && aligned && idx == `IDX_PORT_B_DIR && pstrb[0]
      |=> ##1 port_b_oe == $past(pwdata[7:0], 2)) else $error("dir not applied");
   AST_QUAD_PU: assert property (@(posedge pclk) disable iff (!presetn)
      (quad_pullup & quad_oe) == 4'h0) else $error("quad pull-up on output");
   AST_SECOND_PU: assert property (@(posedge pclk) disable iff (!presetn)
      (second_pullup & second_oe) == 8'h00) else $error("second pull-up on output");
   AST_PU_ON: assert property (@(posedge pclk) disable iff (!presetn)
      access && pwrite && aligned && idx == `IDX_QUAD_PULLUP && pstrb[0] && r_q.quad_dir == 4'h0
      |=> ##1 quad_pullup == $past(pwdata[3:0], 2)) else $error("pull-up write lost");
   AST_B_RW: assert property (@(posedge pclk) disable iff (!presetn)
      access && pwrite && aligned && idx == `IDX_PORT_B_DATA && pstrb[0]
      |=> r_q.port_b_out == $past(pwdata[7:0])) else $error("port b write lost");
   AST_B_OUT: assert property (@(posedge pclk) disable iff (!presetn)
      ##2 (port_b_out & port_b_oe) == ($past(r_q.port_b_out & r_q.port_b_dir)))
      else $error("port b drive wrong");
   AST_READY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready) else $error("pready held");
   AST_A_OUT: assert property (@(posedge pclk) disable iff (!presetn)
      ##2 port_a_out == $past(r_q.port_a_out & r_q.port_a_dir))
      else $error("port a drive wrong");
   AST_A_OE: assert property (@(posedge pclk) disable iff (!presetn)
      ##2 port_a_oe == $past(r_q.port_a_dir))
      else $error("port a enable wrong");
   AST_SECOND_OUT: assert property (@(posedge pclk) disable iff (!presetn)
      ##2 second_out == $past(r_q.second_out & r_q.second_dir))
      else $error("second port drive wrong");
   AST_QUAD_OE: assert property (@(posedge pclk) disable iff (!presetn)
      ##2 quad_oe == $past(r_q.quad_dir))
      else $error("quad enable wrong");
   AST_NARROW_OUT: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 narrow_out == $past(r_q.narrow_out))
      else $error("narrow drive wrong");
   AST_DIR_READ_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pwrite && aligned && (idx == `IDX_PORT_A_DIR || idx == `IDX_PORT_B_DIR
      || idx == `IDX_SECOND_DIR || idx == `IDX_QUAD_DIR)
      |=> prdata == 32'h0000_0000 && pready)
      else $error("direction read not zero");
   AST_ERR_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      access && pwrite && !aligned
      |=> pslverr && $stable(r_q.port_b_out))
      else $error("refused write landed");
   AST_IN_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      access && pwrite && aligned && idx == `IDX_INPUT_LEVELS
      |=> pready && !pslverr)
      else $error("input port write answered wrong");

   COV_B_WRITE: cover property (@(posedge pclk) disable iff (!presetn)
      access && pwrite && idx == `IDX_PORT_B_DATA);
   COV_IN_READ: cover property (@(posedge pclk) disable iff (!presetn)
      access && !pwrite && idx == `IDX_INPUT_LEVELS);
   COV_ERR: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
   COV_QUAD_PU: cover property (@(posedge pclk) disable iff (!presetn) quad_pullup == 4'hf);
   COV_B_DRIVE: cover property (@(posedge pclk) disable iff (!presetn) port_b_oe == 8'hff);

endmodule

/* File: test/pin_wire.sv */
`timescale 1ns/10ps
// outside world of one port: resolves each pin from device drive, pull-up and outside level
module pin_wire #(
   parameter int W = 8
) (
   input wire logic [W-1:0] drv,
   input wire logic [W-1:0] oe,
   input wire logic [W-1:0] pu,
   input wire logic [W-1:0] ext,
   output logic [W-1:0] lvl
);
   // released pin floats to the pull-up, else to whatever the outside drives
   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         lvl[i] = oe[i] ? drv[i] : (pu[i] ? 1'b1 : ext[i]);
      end
   end
endmodule

/* File: test/port_pins_test.sv */
`timescale 1ns/10ps
`include "port_pins_defs.svh"
module port_pins_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [3:0] pstrb, q_in, q_out, q_oe, q_pu, ext_q, qd, qp;
   logic [7:0] in7, a_in, b_in, s_in, a_out, a_oe, b_out, b_oe, s_out, s_oe, s_pu;
   logic [7:0] ext_a, ext_b, ext_s, d, dir, sp;
   logic [4:0] n_out;
   int err_total, checks_done;

   port_pins port_pins_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .input_port_pins(in7), .port_a_in(a_in),
      .port_b_in(b_in), .second_in(s_in), .quad_in(q_in), .narrow_in(n_out),
      .port_a_out(a_out), .port_a_oe(a_oe), .port_b_out(b_out), .port_b_oe(b_oe),
      .second_out(s_out), .second_oe(s_oe), .second_pullup(s_pu), .quad_out(q_out),
      .quad_oe(q_oe), .quad_pullup(q_pu), .narrow_out(n_out));
   pin_wire pin_wire_i (.drv(a_out), .oe(a_oe), .pu(8'h00), .ext(ext_a), .lvl(a_in));
   pin_wire pin_wire_b_i (.drv(b_out), .oe(b_oe), .pu(8'h00), .ext(ext_b), .lvl(b_in));
   pin_wire pin_wire_s_i (.drv(s_out), .oe(s_oe), .pu(s_pu), .ext(ext_s), .lvl(s_in));
   pin_wire #(.W(4)) pin_wire_q_i (.drv(q_out), .oe(q_oe), .pu(q_pu), .ext(ext_q), .lvl(q_in));

   function automatic logic [7:0] gated(input logic [7:0] v, input logic [7:0] m);
      return v & m;
   endfunction

   function automatic logic [31:0] ba(input logic [7:0] idx);
      return {22'h0, idx, 2'b00};
   endfunction

   // read-back: driven bits give the latch, released bits the resolved pin
   function automatic logic [7:0] seen(input logic [7:0] dat, input logic [7:0] oe,
                                       input logic [7:0] pin);
      return (dat & oe) | (pin & ~oe);
   endfunction

   task automatic close_out;
      if (err_total == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [31:0] addr, input logic [7:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      if (pready !== 1'b1)
      begin
         err_total++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   initial
   begin
      #100us;
      err_total++;
      close_out();
   end

   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, err_total, checks_done} = '0;
      {in7, ext_a, ext_b, ext_s, ext_q} = '0;
      pstrb = 4'hf;
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      void'($urandom(32'h71bd4322));
      @(posedge pclk);
      apb(1'b0, ba(`IDX_PORT_B_DATA), 8'h00);
      chk(rd, 32'h0);
      chk(32'(b_oe), 32'h0);
      chk(32'(q_pu), 32'h0);
      for (int k = 0; k < 24; k++)
      begin
         d = (k == 0) ? 8'hff : 8'($urandom);
         dir = (k == 1) ? 8'hff : 8'($urandom);
         qd = (k == 2) ? 4'h0 : 4'($urandom);
         qp = (k == 0) ? 4'hf : 4'($urandom);
         sp = 8'($urandom);
         {ext_a, ext_b, ext_s, ext_q} <= 28'($urandom);
         in7 <= 8'($urandom);
         apb(1'b1, ba(`IDX_PORT_B_DIR), dir);
         apb(1'b1, ba(`IDX_PORT_B_DATA), d);
         apb(1'b1, ba(`IDX_PORT_A_DIR), ~dir);
         apb(1'b1, ba(`IDX_PORT_A_DATA), d);
         apb(1'b1, ba(`IDX_QUAD_DIR), {4'h0, qd});
         apb(1'b1, ba(`IDX_QUAD_PULLUP), {4'h0, qp});
         apb(1'b1, ba(`IDX_SECOND_DIR), dir);
         apb(1'b1, ba(`IDX_SECOND_PULLUP), sp);
         apb(1'b1, ba(`IDX_SECOND_DATA), d);
         apb(1'b1, ba(`IDX_QUAD_DATA), d);
         apb(1'b1, ba(`IDX_NARROW_DATA), d);
         apb(1'b1, ba(`IDX_INPUT_LEVELS), ~in7);
         chk(32'(err), 32'h0);
         apb(1'b0, ba(`IDX_PORT_B_DATA), 8'h00);
         chk(rd, 32'(d));
         chk(32'(b_oe), 32'(dir));
         chk(32'(b_out), 32'(gated(d, dir)));
         chk(32'(a_out), 32'(gated(d, ~dir)));
         chk(32'(q_pu), 32'(gated({4'h0, qp}, {4'h0, ~qd})));
         chk(32'(s_pu), 32'(gated(sp, ~dir)));
         chk(32'(a_oe), 32'(gated(8'hff, ~dir)));
         chk(32'(s_out), 32'(gated(d, dir)));
         chk(32'(s_oe), 32'(dir));
         chk(32'(q_out), 32'(d[3:0] & qd));
         chk(32'(q_oe), 32'(qd));
         chk(32'(n_out), 32'(d[4:0]));
         apb(1'b0, ba(`IDX_PORT_A_DATA), 8'h00);
         chk(rd, 32'(seen(d, ~dir, ext_a)));
         apb(1'b0, ba(`IDX_SECOND_DATA), 8'h00);
         chk(rd, 32'(seen(d, dir, ext_s | sp)));
         apb(1'b0, ba(`IDX_QUAD_DATA), 8'h00);
         chk(rd, 32'(seen(d | 8'hf0, {4'hf, qd}, {4'h0, ext_q | qp})));
         apb(1'b0, ba(`IDX_QUAD_PULLUP), 8'h00);
         chk(rd, 32'({4'hf, qp}));
         apb(1'b0, ba(`IDX_NARROW_DATA), 8'h00);
         chk(rd, 32'(d | 8'he0));
         apb(1'b0, ba(`IDX_PORT_B_DIR), 8'h00);
         chk(rd, 32'h0);
         apb(1'b0, ba(`IDX_INPUT_LEVELS), 8'h00);
         chk(rd, 32'(in7));
      end
      apb(1'b1, ba(`IDX_PORT_B_DATA) | 32'h1, 8'h5a);
      chk(32'(err), 32'h1);
      apb(1'b0, ba(`IDX_PORT_B_DATA), 8'h00);
      chk(rd, 32'(d));
      apb(1'b0, 32'h400, 8'h00);
      chk(32'(err), 32'h1);
      close_out();
   end
endmodule
